// ===== bench/test_usb_device_ep0_bulk_in_control.sv
// Self-checking bench joining host end and device end over the link interface
`default_nettype none
module test_usb_device_ep0_bulk_in_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dma_ack = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, perr, dma_req, ep0_irq, tx_irq;
  logic cmd_valid = 1'b0, cmd_ep = 1'b0, cmd_dpid = 1'b0, cmd_ack_ok = 1'b1;
  usb_ep_pkg::token_e cmd_pid = usb_ep_pkg::PID_SETUP;
  logic [10:0] cmd_len = 11'h000, res_len, rlen;
  logic cmd_ready, res_valid, res_dpid, rdp;
  usb_ep_pkg::resp_e res_code, rcode;
  int n_errors = 0, checks = 0, n_ep0 = 0, n_tx = 0, n;
  usb_link_if link ();
  usb_ep_host usb_ep_host_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_pid(cmd_pid), .cmd_ep(cmd_ep), .cmd_dpid(cmd_dpid), .cmd_len(cmd_len),
    .cmd_ack_ok(cmd_ack_ok), .res_valid(res_valid), .res_code(res_code), .res_len(res_len), .res_dpid(res_dpid));
  usb_ep_device usb_ep_device_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link), .dma_req(dma_req), .dma_ack(dma_ack), .ep0_irq(ep0_irq), .tx_irq(tx_irq));
  usb_ep_monitor usb_ep_monitor_inst (.clk_sys(clk_sys), .rstn(rstn), .xact_valid(link.xact_valid),
    .xact_pid(link.xact_pid), .xact_ep(link.xact_ep), .xact_dpid(link.xact_dpid), .xact_len(link.xact_len),
    .xact_ack_ok(link.xact_ack_ok), .resp_valid(link.resp_valid), .resp_code(link.resp_code),
    .resp_len(link.resp_len), .resp_dpid(link.resp_dpid));
  always #5 clk_sys = ~clk_sys;
  // Pulses are counted at the falling edge, where they have settled
  always @(negedge clk_sys)
  begin
    if (ep0_irq === 1'b1)
      n_ep0++;
    if (tx_irq === 1'b1)
      n_tx++;
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic xact(input usb_ep_pkg::token_e p, input logic ep, input logic dp, input logic [10:0] len,
                      input logic ack);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_pid <= p;
    cmd_ep <= ep;
    cmd_dpid <= dp;
    cmd_len <= len;
    cmd_ack_ok <= ack;
    // Ready and the answer are read at the falling edge to avoid racing the launching edge
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1)
      @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    @(negedge clk_sys);
    while (res_valid !== 1'b1)
      @(negedge clk_sys);
    rcode = res_code;
    rlen = res_len;
    rdp = res_dpid;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_code(input usb_ep_pkg::resp_e got, input usb_ep_pkg::resp_e exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t answer %s expected %s", $time, got.name(), exp.name());
    end
  endtask
  task automatic t_regs();
    rd(usb_ep_pkg::ADDR_TX_MAX_PAYLOAD);
    chk(rdv, 32'h0000_0040);
    rd(usb_ep_pkg::ADDR_EP0_PHASE);
    chk(rdv, 32'h0000_0000);
    rd(8'h3C);
    chk_bit(perr, 1'b1);
    chk(rdv, 32'h0000_0000);
    wr(usb_ep_pkg::ADDR_TX_MAX_PAYLOAD, 32'h0000_0200);
    rd(usb_ep_pkg::ADDR_TX_MAX_PAYLOAD);
    chk(rdv, 32'h0000_0200);
  endtask
  task automatic t_setup();
    n = n_ep0;
    xact(usb_ep_pkg::PID_SETUP, 1'b0, 1'b0, 11'h008, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_ACK);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk_bit(rdv[usb_ep_pkg::B0_RX_READY], 1'b1);
    chk_bit(n_ep0 > n, 1'b1);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0040);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk_bit(rdv[usb_ep_pkg::B0_RX_READY], 1'b0);
  endtask
  task automatic t_rx();
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h1);
    xact(usb_ep_pkg::PID_OUT, 1'b0, 1'b1, 11'h041, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_STALL);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk_bit(rdv[usb_ep_pkg::B0_STALL_SENT], 1'b1);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0000);
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h1);
    xact(usb_ep_pkg::PID_IN, 1'b0, 1'b0, 11'h000, 1'b1);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk_bit(rdv[usb_ep_pkg::B0_STALL_SENT], 1'b0);
    chk_bit(rdv[usb_ep_pkg::B0_PREM_END], 1'b1);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0080);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk_bit(rdv[usb_ep_pkg::B0_PREM_END], 1'b0);
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h1);
    xact(usb_ep_pkg::PID_OUT, 1'b0, 1'b1, 11'h040, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_ACK);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0048);
    xact(usb_ep_pkg::PID_OUT, 1'b0, 1'b0, 11'h008, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_STALL);
  endtask
  task automatic t_tx();
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h2);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0008);
    xact(usb_ep_pkg::PID_IN, 1'b0, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_STALL);
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h2);
    xact(usb_ep_pkg::PID_OUT, 1'b0, 1'b1, 11'h004, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_STALL);
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h2);
    xact(usb_ep_pkg::PID_OUT, 1'b0, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_STALL);
    wr(usb_ep_pkg::ADDR_TX_LOAD_LEN, 32'h8);
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h2);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0002);
    xact(usb_ep_pkg::PID_IN, 1'b0, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_DATA);
    chk({21'h0, rlen}, 32'h8);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0002);
    xact(usb_ep_pkg::PID_OUT, 1'b0, 1'b1, 11'h000, 1'b1);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk_bit(rdv[usb_ep_pkg::B0_PREM_END], 1'b1);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0080);
    wr(usb_ep_pkg::ADDR_EP0_PHASE, 32'h2);
    xact(usb_ep_pkg::PID_IN, 1'b0, 1'b0, 11'h000, 1'b1);
    chk_bit(rcode == usb_ep_pkg::RESP_DATA, 1'b0);
    wr(usb_ep_pkg::ADDR_CSR0, 32'h0000_0020);
    xact(usb_ep_pkg::PID_IN, 1'b0, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_STALL);
    rd(usb_ep_pkg::ADDR_CSR0);
    chk(rdv[5:2], 4'h1);
  endtask
  // Bulk packet: load one, fetch it and check the data toggle
  task automatic bulk_in(input logic ack, input logic dp);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_3001);
    xact(usb_ep_pkg::PID_IN, 1'b1, 1'b0, 11'h000, ack);
    chk_code(rcode, usb_ep_pkg::RESP_DATA);
    chk_bit(rdp, dp);
  endtask
  task automatic t_bulk();
    wr(usb_ep_pkg::ADDR_TX_LOAD_LEN, 32'h10);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_3000);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk_bit(dma_req, 1'b1);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_3001);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(rdv[1:0], 2'h3);
    chk_bit(dma_req, 1'b0);
    n = n_tx;
    xact(usb_ep_pkg::PID_IN, 1'b1, 1'b0, 11'h000, 1'b1);
    chk({21'h0, rlen}, 32'h10);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(rdv[1:0], 2'h0);
    chk_bit(n_tx > n, 1'b1);
    xact(usb_ep_pkg::PID_IN, 1'b1, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_NAK);
    bulk_in(1'b0, 1'b1);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_3040);
    bulk_in(1'b1, 1'b0);
    bulk_in(1'b1, 1'b1);
  endtask
  task automatic t_double();
    wr(usb_ep_pkg::ADDR_TX_FIFO_SIZE_CONFIG, 32'h10);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_2001);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(rdv[1:0], 2'h2);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_2001);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(rdv[1:0], 2'h3);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_2008);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(rdv[1:0], 2'h2);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_2008);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(rdv[1:0], 2'h0);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_3400);
    n = n_tx;
    @(posedge clk_sys);
    dma_ack <= 1'b1;
    @(posedge clk_sys);
    dma_ack <= 1'b0;
    xact(usb_ep_pkg::PID_IN, 1'b1, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_DATA);
    rd(usb_ep_pkg::ADDR_TXCSR);
    chk(n_tx, n);
    wr(usb_ep_pkg::ADDR_TXCSR, 32'h0000_6001);
    xact(usb_ep_pkg::PID_IN, 1'b1, 1'b0, 11'h000, 1'b1);
    chk_code(rcode, usb_ep_pkg::RESP_NAK);
  endtask
  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_setup();
    t_rx();
    t_tx();
    t_bulk();
    t_double();
    print_verdict();
  end
  // Whole sequence needs well under 3000 cycles
  initial
  begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== bench/usb_ep_monitor.sv
// Concurrent checks on the link between the host end and the device end
`default_nettype none
module usb_ep_monitor #(
  parameter logic [10:0] EP0_MAX = usb_ep_pkg::EP0_MAX_PKT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic xact_valid,
  input wire usb_ep_pkg::token_e xact_pid,
  input wire logic xact_ep,
  input wire logic xact_dpid,
  input wire logic [10:0] xact_len,
  input wire logic xact_ack_ok,
  input wire logic resp_valid,
  input wire usb_ep_pkg::resp_e resp_code,
  input wire logic [10:0] resp_len,
  input wire logic resp_dpid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire take = xact_valid && !resp_valid;
  property p_answer_next;
    take |=> resp_valid;
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("no answer one cycle after take");
  property p_answer_pulse;
    resp_valid |=> !resp_valid;
  endproperty
  a_answer_pulse: assert property (p_answer_pulse) else $error("answer longer than one cycle");
  property p_setup_ack;
    take && !xact_ep && xact_pid == usb_ep_pkg::PID_SETUP |=> resp_code == usb_ep_pkg::RESP_ACK;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acknowledged");
  // Oversize OUT on endpoint 0 stalls in every state
  property p_oversize;
    take && xact_pid == usb_ep_pkg::PID_OUT && !xact_ep && xact_len > EP0_MAX
      |=> resp_code == usb_ep_pkg::RESP_STALL;
  endproperty
  a_oversize: assert property (p_oversize) else $error("oversize out not stalled");
  property p_data_on_in;
    resp_valid && resp_code == usb_ep_pkg::RESP_DATA |-> xact_pid == usb_ep_pkg::PID_IN;
  endproperty
  a_data_on_in: assert property (p_data_on_in) else $error("data answer to a non-in token");
  property p_bulk_no_ack;
    take && xact_ep && xact_pid == usb_ep_pkg::PID_IN |=> resp_code != usb_ep_pkg::RESP_ACK;
  endproperty
  a_bulk_no_ack: assert property (p_bulk_no_ack) else $error("bulk in answered with ack");
  property p_hold;
    !resp_valid |-> $stable(resp_code) && $stable(resp_len) && $stable(resp_dpid);
  endproperty
  a_hold: assert property (p_hold) else $error("answer fields changed between answers");
  property p_host_hold;
    take |=> xact_valid && $stable(xact_pid) && $stable(xact_len) && $stable(xact_ep);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host released token early");
  c_stall: cover property (resp_valid && resp_code == usb_ep_pkg::RESP_STALL);
  c_bulk: cover property (resp_valid && resp_code == usb_ep_pkg::RESP_DATA && xact_ep);
  c_setup: cover property (take && xact_pid == usb_ep_pkg::PID_SETUP);
endmodule
`default_nettype wire

// ===== core/usb_ep_device.sv
// Device end: endpoint 0 control transfers and bulk IN endpoint with APB registers
`default_nettype none
module usb_ep_device #(
  parameter logic [10:0] EP0_MAX = usb_ep_pkg::EP0_MAX_PKT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  usb_link_if.device link,
  output logic dma_req,
  input wire logic dma_ack,
  output logic ep0_irq,
  output logic tx_irq
);
  usb_ep_pkg::ep0_state_e state;
  usb_ep_pkg::resp_e e0_code;
  logic rx_ready, tx0_ready, data_end, stall_req, stall_sent, prem_end;
  logic [15:0] tx_maxp;
  logic [4:0] tx_ctl;
  logic dbl_buf, toggle;
  logic [10:0] load_len;
  logic [1:0] cnt;
  logic rd_ptr;
  logic [10:0] len_q [2];
  logic e0_stall, e0_prem, e0_rx, e0_sent, e0_done;
  logic [31:0] rd_mux;

  // Bus decode
  wire logic wr = psel && penable && pwrite;
  wire logic sel_csr0 = paddr == usb_ep_pkg::ADDR_CSR0;
  wire logic sel_txcsr = paddr == usb_ep_pkg::ADDR_TXCSR;
  wire logic sel_maxp = paddr == usb_ep_pkg::ADDR_TX_MAX_PAYLOAD;
  wire logic sel_fifosz = paddr == usb_ep_pkg::ADDR_TX_FIFO_SIZE_CONFIG;
  wire logic sel_phase = paddr == usb_ep_pkg::ADDR_EP0_PHASE;
  wire logic sel_load = paddr == usb_ep_pkg::ADDR_TX_LOAD_LEN;
  wire logic mapped = sel_csr0 || sel_txcsr || sel_maxp || sel_fifosz || sel_phase || sel_load;
  wire logic wr_csr0 = wr && sel_csr0;
  wire logic wr_txcsr = wr && sel_txcsr;
  wire logic wr_phase = wr && sel_phase;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Link decode
  wire logic take = link.xact_valid && !link.resp_valid;
  wire logic tok0 = take && !link.xact_ep;
  wire logic tok1 = take && link.xact_ep;
  wire logic is_setup = link.xact_pid == usb_ep_pkg::PID_SETUP;
  wire logic is_in = link.xact_pid == usb_ep_pkg::PID_IN;

  // Endpoint 0 token handling
  always_comb
  begin
    e0_code = usb_ep_pkg::RESP_NAK;
    e0_stall = 1'b0;
    e0_prem = 1'b0;
    e0_rx = 1'b0;
    e0_sent = 1'b0;
    e0_done = 1'b0;
    if (tok0)
    begin
      if (is_setup)
      begin
        e0_code = usb_ep_pkg::RESP_ACK;
        e0_rx = 1'b1;
        e0_prem = state != usb_ep_pkg::EP0_IDLE;
      end
      else if (stall_req)
        e0_stall = 1'b1;
      else
      begin
        case (state)
          usb_ep_pkg::EP0_RX:
          begin
            if (is_in)
            begin
              // An IN before data end means the host cut the write short
              if (data_end)
              begin
                e0_code = usb_ep_pkg::RESP_DATA;
                e0_done = 1'b1;
              end
              else
                e0_prem = 1'b1;
            end
            else if (data_end)
              e0_stall = 1'b1;
            else if (link.xact_len > EP0_MAX)
              e0_stall = 1'b1;
            else if (!rx_ready)
            begin
              e0_code = usb_ep_pkg::RESP_ACK;
              e0_rx = 1'b1;
            end
          end
          usb_ep_pkg::EP0_TX:
          begin
            if (is_in)
            begin
              if (tx0_ready)
              begin
                e0_code = usb_ep_pkg::RESP_DATA;
                e0_sent = 1'b1;
              end
              else if (data_end)
                e0_stall = 1'b1;
            end
            else if (link.xact_len != 11'h000 || !link.xact_dpid)
              e0_stall = 1'b1;
            else
            begin
              e0_code = usb_ep_pkg::RESP_ACK;
              e0_done = data_end;
              e0_prem = !data_end;
            end
          end
          default:
          begin
            // No data phase: the status IN gets a zero-length packet
            if (is_in && !rx_ready)
            begin
              e0_code = usb_ep_pkg::RESP_DATA;
              e0_done = 1'b1;
            end
            else if (!is_in)
              e0_stall = 1'b1;
          end
        endcase
      end
    end
    if (e0_stall)
      e0_code = usb_ep_pkg::RESP_STALL;
  end

  wire logic go_idle = e0_stall || e0_prem || e0_done || (tok0 && is_setup);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      state <= usb_ep_pkg::EP0_IDLE;
    else if (go_idle)
      state <= usb_ep_pkg::EP0_IDLE;
    else if (wr_phase)
      state <= pwdata[1:0] == usb_ep_pkg::PHASE_RX ? usb_ep_pkg::EP0_RX :
               pwdata[1:0] == usb_ep_pkg::PHASE_TX ? usb_ep_pkg::EP0_TX : usb_ep_pkg::EP0_IDLE;
  end

  // Endpoint 0 flags: for rx_ready, stall_sent and prem_end software clear first, hardware set wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_ready <= 1'b0;
      tx0_ready <= 1'b0;
      data_end <= 1'b0;
      stall_req <= 1'b0;
      stall_sent <= 1'b0;
      prem_end <= 1'b0;
      ep0_irq <= 1'b0;
    end
    else
    begin
      rx_ready <= (rx_ready && !(wr_csr0 && pwdata[usb_ep_pkg::B0_RX_SERVICED])) || e0_rx;
      tx0_ready <= ((tx0_ready || (wr_csr0 && pwdata[usb_ep_pkg::B0_TX_READY])) && !e0_sent && !e0_prem)
                   && !go_idle;
      data_end <= (data_end && !go_idle) || (wr_csr0 && pwdata[usb_ep_pkg::B0_DATA_END]);
      stall_req <= (wr_csr0 ? pwdata[usb_ep_pkg::B0_STALL_REQ] : stall_req) && !e0_stall;
      stall_sent <= (stall_sent && !(wr_csr0 && !pwdata[usb_ep_pkg::B0_STALL_SENT])) || e0_stall;
      prem_end <= (prem_end && !(wr_csr0 && pwdata[usb_ep_pkg::B0_PREM_SERVICED])) || e0_prem;
      ep0_irq <= e0_stall || e0_prem || e0_rx || e0_sent || e0_done;
    end
  end

  // Bulk IN endpoint
  wire logic [1:0] cap = dbl_buf ? usb_ep_pkg::FIFO_SLOTS : 2'h1;
  wire logic room = cnt < cap;
  wire logic bulk_ok = !tx_ctl[usb_ep_pkg::BT_ISO - usb_ep_pkg::BT_CTL_LO]
                       && tx_ctl[usb_ep_pkg::BT_DIR_TX - usb_ep_pkg::BT_CTL_LO];
  wire logic force_tog = tx_ctl[usb_ep_pkg::BT_FORCE_TOGGLE - usb_ep_pkg::BT_CTL_LO];
  wire logic dma_on = tx_ctl[usb_ep_pkg::BT_DMA_ENABLE - usb_ep_pkg::BT_CTL_LO];
  wire logic quiet = dma_on && tx_ctl[usb_ep_pkg::BT_DMA_SUPPRESS - usb_ep_pkg::BT_CTL_LO];
  wire logic [10:0] payload = tx_maxp[usb_ep_pkg::PAYLOAD_BITS-1:0];
  wire logic sw_load = wr_txcsr && pwdata[usb_ep_pkg::BT_TX_READY];
  wire logic enq = (sw_load || (dma_ack && dma_on)) && room;
  wire logic [10:0] enq_len = sw_load ? load_len : payload;
  wire logic tx_send = tok1 && is_in && bulk_ok && cnt != 2'h0;
  wire logic tx_pop = tx_send && (link.xact_ack_ok || force_tog);
  wire logic discard = wr_txcsr && pwdata[usb_ep_pkg::BT_FIFO_DISCARD] && cnt != 2'h0 && !tx_pop;
  wire logic [1:0] next_cnt = cnt + {1'b0, enq} - {1'b0, tx_pop || discard};
  wire logic wr_slot = rd_ptr ^ cnt[0];

  assign dma_req = dma_on && room;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 2'h0;
      rd_ptr <= 1'b0;
      toggle <= usb_ep_pkg::TOGGLE_INIT;
      tx_irq <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      rd_ptr <= rd_ptr ^ (tx_pop || discard);
      if (wr_txcsr && pwdata[usb_ep_pkg::BT_CLEAR_TOGGLE])
        toggle <= usb_ep_pkg::TOGGLE_INIT;
      else if (tx_pop)
        toggle <= !toggle;
      // Unless quiet (DMA on with suppress), tx_irq pulses when a packet leaves or a load still leaves room
      tx_irq <= !quiet && (tx_pop || (enq && next_cnt < cap));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (enq)
      len_q[wr_slot] <= enq_len;
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_ctl <= 5'h00;
      tx_maxp <= usb_ep_pkg::TX_MAX_PAYLOAD_RESET;
      dbl_buf <= 1'b0;
      load_len <= 11'h000;
    end
    else
    begin
      if (wr_txcsr)
        tx_ctl <= pwdata[usb_ep_pkg::BT_CTL_HI:usb_ep_pkg::BT_CTL_LO];
      if (wr && sel_maxp)
        tx_maxp <= pwdata[15:0];
      if (wr && sel_fifosz)
        dbl_buf <= pwdata[usb_ep_pkg::BF_DOUBLE_BUFFER];
      if (wr && sel_load)
        load_len <= pwdata[10:0];
    end
  end

  // Link answer, one cycle after the token is taken
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      link.resp_valid <= 1'b0;
      link.resp_code <= usb_ep_pkg::RESP_NAK;
      link.resp_len <= 11'h000;
      link.resp_dpid <= 1'b0;
    end
    else
    begin
      link.resp_valid <= take;
      if (tok0)
      begin
        link.resp_code <= e0_code;
        link.resp_len <= e0_sent ? load_len : 11'h000;
        link.resp_dpid <= e0_done || e0_sent;
      end
      else if (tok1)
      begin
        link.resp_code <= tx_send ? usb_ep_pkg::RESP_DATA : usb_ep_pkg::RESP_NAK;
        link.resp_len <= tx_send ? len_q[rd_ptr] : 11'h000;
        link.resp_dpid <= toggle;
      end
    end
  end

  // Read data is captured in the setup cycle
  wire logic tx_ready_rd = cnt >= cap;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_csr0)
      rd_mux[7:0] = {1'b0, 1'b0, stall_req, prem_end, data_end, stall_sent, tx0_ready, rx_ready};
    else if (sel_txcsr)
    begin
      rd_mux[usb_ep_pkg::BT_CTL_HI:usb_ep_pkg::BT_CTL_LO] = tx_ctl;
      rd_mux[usb_ep_pkg::BT_FIFO_OCCUPIED] = cnt != 2'h0;
      rd_mux[usb_ep_pkg::BT_TX_READY] = tx_ready_rd;
    end
    else if (sel_maxp)
      rd_mux[15:0] = tx_maxp;
    else if (sel_fifosz)
      rd_mux[usb_ep_pkg::BF_DOUBLE_BUFFER] = dbl_buf;
    else if (sel_phase)
      rd_mux[1:0] = state == usb_ep_pkg::EP0_RX ? usb_ep_pkg::PHASE_RX :
                    state == usb_ep_pkg::EP0_TX ? usb_ep_pkg::PHASE_TX : 2'h0;
    else if (sel_load)
      rd_mux[10:0] = load_len;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rd_mux;
  end
endmodule
`default_nettype wire

// ===== core/usb_ep_host.sv
// Host controller end: issues one token transaction at a time and returns the answer
`default_nettype none
module usb_ep_host (
  input wire logic clk_sys,
  input wire logic rstn,
  usb_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire usb_ep_pkg::token_e cmd_pid,
  input wire logic cmd_ep,
  input wire logic cmd_dpid,
  input wire logic [10:0] cmd_len,
  input wire logic cmd_ack_ok,
  output logic res_valid,
  output usb_ep_pkg::resp_e res_code,
  output logic [10:0] res_len,
  output logic res_dpid
);
  logic busy;
  wire logic take_cmd;
  wire logic got_resp;

  assign cmd_ready = !busy;
  assign take_cmd = cmd_valid && !busy;
  assign got_resp = busy && link.resp_valid;
  assign link.xact_valid = busy;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      link.xact_pid <= usb_ep_pkg::PID_SETUP;
      link.xact_ep <= 1'b0;
      link.xact_dpid <= 1'b0;
      link.xact_len <= 11'h000;
      link.xact_ack_ok <= 1'b0;
    end
    else if (take_cmd)
    begin
      busy <= 1'b1;
      link.xact_pid <= cmd_pid;
      link.xact_ep <= cmd_ep;
      link.xact_dpid <= cmd_dpid;
      // Short and zero-length packets pass unchanged; a SETUP, or a zero-length DATA1 status OUT before data end, flags a premature end of the IN data phase
      link.xact_len <= cmd_len;
      link.xact_ack_ok <= cmd_ack_ok;
    end
    else if (got_resp)
    begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      res_valid <= 1'b0;
      res_code <= usb_ep_pkg::RESP_NAK;
      res_len <= 11'h000;
      res_dpid <= 1'b0;
    end
    else
    begin
      res_valid <= got_resp;
      if (got_resp)
      begin
        res_code <= link.resp_code;
        res_len <= link.resp_len;
        res_dpid <= link.resp_dpid;
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/usb_ep_pkg.sv
// Shared constants and types for the endpoint 0 / bulk IN link logic
`default_nettype none
package usb_ep_pkg;
  localparam logic [7:0] ADDR_CSR0 = 8'h00;
  localparam logic [7:0] ADDR_TXCSR = 8'h04;
  localparam logic [7:0] ADDR_TX_MAX_PAYLOAD = 8'h08;
  localparam logic [7:0] ADDR_TX_FIFO_SIZE_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_EP0_PHASE = 8'h10;
  localparam logic [7:0] ADDR_TX_LOAD_LEN = 8'h14;
  // ep0_control_status bits
  localparam int B0_RX_READY = 0;
  localparam int B0_TX_READY = 1;
  localparam int B0_STALL_SENT = 2;
  localparam int B0_DATA_END = 3;
  localparam int B0_PREM_END = 4;
  localparam int B0_STALL_REQ = 5;
  localparam int B0_RX_SERVICED = 6;
  localparam int B0_PREM_SERVICED = 7;
  // tx_endpoint_control_status bits
  localparam int BT_TX_READY = 0;
  localparam int BT_FIFO_OCCUPIED = 1;
  localparam int BT_FIFO_DISCARD = 3;
  localparam int BT_CLEAR_TOGGLE = 6;
  localparam int BT_CTL_LO = 10;
  localparam int BT_CTL_HI = 14;
  localparam int BT_DMA_SUPPRESS = 10;
  localparam int BT_FORCE_TOGGLE = 11;
  localparam int BT_DMA_ENABLE = 12;
  localparam int BT_DIR_TX = 13;
  localparam int BT_ISO = 14;
  localparam int BF_DOUBLE_BUFFER = 4;
  localparam int PAYLOAD_BITS = 11;
  localparam logic [1:0] PHASE_RX = 2'h1;
  localparam logic [1:0] PHASE_TX = 2'h2;
  localparam logic [15:0] TX_MAX_PAYLOAD_RESET = 16'h0040;
  localparam logic TOGGLE_INIT = 1'b0;
  localparam logic [1:0] FIFO_SLOTS = 2'h2;
  localparam logic [10:0] EP0_MAX_PKT = 11'h040;
  typedef enum logic [1:0] {PID_SETUP, PID_OUT, PID_IN} token_e;
  typedef enum logic [1:0] {RESP_ACK, RESP_NAK, RESP_STALL, RESP_DATA} resp_e;
  typedef enum logic [1:0] {EP0_IDLE, EP0_TX, EP0_RX} ep0_state_e;
endpackage
`default_nettype wire

// ===== core/usb_link_if.sv
// Transaction-level link between the host controller end and the device end
`default_nettype none
interface usb_link_if;
  logic xact_valid;
  usb_ep_pkg::token_e xact_pid;
  logic xact_ep;
  logic xact_dpid;
  logic [10:0] xact_len;
  logic xact_ack_ok;
  logic resp_valid;
  usb_ep_pkg::resp_e resp_code;
  logic [10:0] resp_len;
  logic resp_dpid;
  modport device (input xact_valid, xact_pid, xact_ep, xact_dpid, xact_len, xact_ack_ok,
                  output resp_valid, resp_code, resp_len, resp_dpid);
  modport host (output xact_valid, xact_pid, xact_ep, xact_dpid, xact_len, xact_ack_ok,
                input resp_valid, resp_code, resp_len, resp_dpid);
endinterface
`default_nettype wire
